// ===== common/adop_pkg.sv
package adop_pkg;

    // sample word and lane layout
    localparam int ADOP_SAMPLE_W = 12;
    localparam int ADOP_LANES = ADOP_SAMPLE_W / 2;
    localparam int ADOP_LATENCY = 6;

    // serial frame: rw bit, 7-bit address, 8 data bits, msb first
    localparam int ADOP_FRAME_BITS = 16;
    localparam logic [3:0] ADOP_HDR_LAST = 4'h7;
    localparam logic [3:0] ADOP_FRAME_LAST = 4'hf;

    // mode register addresses
    localparam logic [6:0] ADOP_ADDR_POWER = 7'h01;
    localparam logic [6:0] ADOP_ADDR_TIMING = 7'h02;
    localparam logic [6:0] ADOP_ADDR_OUTPUT = 7'h03;
    localparam logic [6:0] ADOP_ADDR_FORMAT = 7'h04;

    // writable bits of each mode register, the rest read as zero
    localparam logic [7:0] ADOP_MASK_POWER = 8'h01;
    localparam logic [7:0] ADOP_MASK_TIMING = 8'h0f;
    localparam logic [7:0] ADOP_MASK_OUTPUT = 8'h0f;
    localparam logic [7:0] ADOP_MASK_FORMAT = 8'h01;

    // field positions
    localparam int ADOP_POWER_SLEEP_BIT = 0;
    localparam int ADOP_TIMING_DCS_BIT = 0;
    localparam int ADOP_TIMING_PHASE_LSB = 1;
    localparam int ADOP_TIMING_INV_BIT = 3;
    localparam int ADOP_OUTPUT_TERM_BIT = 3;
    localparam int ADOP_FORMAT_TWOS_BIT = 0;

    // values after reset: awake, stabilizer on, 3.5 ma, offset binary
    localparam logic [7:0] ADOP_RST_POWER = 8'h00;
    localparam logic [7:0] ADOP_RST_TIMING = 8'h01;
    localparam logic [7:0] ADOP_RST_OUTPUT = 8'h00;
    localparam logic [7:0] ADOP_RST_FORMAT = 8'h00;

    // drive current codes
    localparam logic [2:0] ADOP_DRIVE_3M5 = 3'h0;
    localparam logic [2:0] ADOP_DRIVE_4M0 = 3'h1;
    localparam logic [2:0] ADOP_DRIVE_4M5 = 3'h2;
    localparam logic [2:0] ADOP_DRIVE_3M0 = 3'h3;
    localparam logic [2:0] ADOP_DRIVE_2M5 = 3'h4;
    localparam logic [2:0] ADOP_DRIVE_2M1 = 3'h5;
    localparam logic [2:0] ADOP_DRIVE_1M75 = 3'h6;

    // effective configuration handed to the output drivers
    typedef struct packed {
        logic [2:0] drive;
        logic term;
        logic sleep;
        logic dcs;
        logic [1:0] phase;
        logic invert;
        logic twos;
    } adop_cfg_s;

    // state of the configuration front end (clk_i domain)
    typedef struct packed {
        logic [1:0] mode_sync;
        logic [1:0] cs_sync;
        logic [1:0] sck_sync;
        logic [1:0] sdi_sync;
        logic sck_prev;
        logic [3:0] bit_cnt;
        logic [15:0] shift_in;
        logic [7:0] shift_out;
        logic read_op;
        logic sdo_low;
        logic [7:0] reg_power;
        logic [7:0] reg_timing;
        logic [7:0] reg_output;
        logic [7:0] reg_format;
        adop_cfg_s cfg;
    } adop_ctl_s;

    // state of the sample path (encode clock domain, rising edge)
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] twos_sync;
        logic [1:0] inv_sync;
        logic [ADOP_LATENCY-1:0][ADOP_SAMPLE_W:0] pipe;
        logic [ADOP_LANES-1:0] even;
        logic [ADOP_LANES-1:0] odd_hold;
        logic range;
        logic invert;
        logic pos_tog;
    } adop_enc_s;

endpackage

// ===== hdl/adop_top.sv
`timescale 1ns/1ps
`default_nettype none

module adop_top
    import adop_pkg::*;
(
    // configuration clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // encode clock and converter core
    input wire logic encode_pos_in_i,
    input wire logic [ADOP_SAMPLE_W-1:0] core_code_i,
    input wire logic core_out_of_range_i,
    // configuration pins
    input wire logic config_style_select_i,
    input wire logic chip_select_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    output logic serial_data_o,
    output logic serial_data_oe_o,
    // ddr output link
    output logic [ADOP_LANES-1:0] ddr_bit_pair_lane_o,
    output logic sample_strobe_out_o,
    output logic range_exceeded_flag_o,
    // analog driver controls
    output logic [2:0] drive_current_o,
    output logic termination_en_o,
    output logic sleep_o,
    output logic duty_stabilizer_en_o,
    output logic [1:0] strobe_phase_o
);

    // elaboration checks on the fixed layout
    if (ADOP_SAMPLE_W % 2 != 0) begin : g_chk_w
        $error("sample width must be even");
    end
    if (ADOP_LATENCY < 2) begin : g_chk_lat
        $error("pipeline needs at least two stages");
    end

    adop_ctl_s ctl_reg; // configuration state
    adop_ctl_s ctl_next; // its next value
    adop_enc_s enc_reg; // sample path state
    adop_enc_s enc_next; // its next value
    logic neg_tog_reg; // falling-edge copy of the half toggle
    logic [ADOP_LANES-1:0] odd_reg; // odd bits launched at falling edge

    // mode register readback by address
    function automatic logic [7:0] adop_read(input adop_ctl_s s, input logic [6:0] addr);
        logic [7:0] val;
        val = 8'h00;
        unique case (addr)
            ADOP_ADDR_POWER: val = s.reg_power;
            ADOP_ADDR_TIMING: val = s.reg_timing;
            ADOP_ADDR_OUTPUT: val = s.reg_output;
            ADOP_ADDR_FORMAT: val = s.reg_format;
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    // configuration front end: pin synchronisers, serial port, straps
    always_comb begin
        logic sck_rise;
        logic sck_fall;
        logic serial_mode;
        logic [7:0] hdr;
        logic [7:0] wdata;
        logic [2:0] code;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        serial_mode = 1'b0;
        hdr = 8'h00;
        wdata = 8'h00;
        code = 3'h0;
        ctl_next = ctl_reg;
        // two flops on every configuration pin before use
        ctl_next.mode_sync = {ctl_reg.mode_sync[0], config_style_select_i};
        ctl_next.cs_sync = {ctl_reg.cs_sync[0], chip_select_n_i};
        ctl_next.sck_sync = {ctl_reg.sck_sync[0], serial_clk_i};
        ctl_next.sdi_sync = {ctl_reg.sdi_sync[0], serial_data_i};
        ctl_next.sck_prev = ctl_reg.sck_sync[1];
        serial_mode = ~ctl_reg.mode_sync[1];
        sck_rise = ctl_reg.sck_sync[1] & ~ctl_reg.sck_prev;
        sck_fall = ~ctl_reg.sck_sync[1] & ctl_reg.sck_prev;
        if (!serial_mode || ctl_reg.cs_sync[1]) begin
            // frame aborted or idle: restart framing, release sdo
            ctl_next.bit_cnt = 4'h0;
            ctl_next.sdo_low = 1'b0;
            ctl_next.read_op = 1'b0;
        end else begin
            if (sck_rise) begin
                // shift one bit in on the serial clock rising edge
                ctl_next.shift_in = {ctl_reg.shift_in[14:0], ctl_reg.sdi_sync[1]};
                ctl_next.bit_cnt = ctl_reg.bit_cnt + 4'h1;
                hdr = {ctl_reg.shift_in[6:0], ctl_reg.sdi_sync[1]};
                wdata = hdr;
                if (ctl_reg.bit_cnt == ADOP_HDR_LAST) begin
                    // header done: latch direction, preload readback
                    ctl_next.read_op = hdr[7];
                    ctl_next.shift_out = adop_read(ctl_reg, hdr[6:0]);
                end
                if (ctl_reg.bit_cnt == ADOP_FRAME_LAST && !ctl_reg.read_op) begin
                    // last data bit taken: write the addressed register
                    // bit 14 holds the rw flag, so the address sits one below it
                    unique case (ctl_reg.shift_in[13:7])
                        ADOP_ADDR_POWER: ctl_next.reg_power = wdata & ADOP_MASK_POWER;
                        ADOP_ADDR_TIMING: ctl_next.reg_timing = wdata & ADOP_MASK_TIMING;
                        ADOP_ADDR_OUTPUT: ctl_next.reg_output = wdata & ADOP_MASK_OUTPUT;
                        ADOP_ADDR_FORMAT: ctl_next.reg_format = wdata & ADOP_MASK_FORMAT;
                        default: ctl_next.reg_power = ctl_reg.reg_power;
                    endcase
                end
            end
            if (sck_fall) begin
                if (ctl_reg.read_op && ctl_reg.bit_cnt >= 4'h8) begin
                    // present next readback bit, pull low for a zero
                    ctl_next.sdo_low = ~ctl_reg.shift_out[7];
                    ctl_next.shift_out = {ctl_reg.shift_out[6:0], 1'b0};
                end else begin
                    ctl_next.sdo_low = 1'b0;
                end
            end
        end
        // effective configuration
        if (serial_mode) begin
            code = ctl_reg.reg_output[2:0];
            if (code == 3'h7) begin
                code = ADOP_DRIVE_3M5; // unused code falls back to default
            end
            ctl_next.cfg.drive = code;
            ctl_next.cfg.term = ctl_reg.reg_output[ADOP_OUTPUT_TERM_BIT];
            ctl_next.cfg.sleep = ctl_reg.reg_power[ADOP_POWER_SLEEP_BIT];
            ctl_next.cfg.dcs = ctl_reg.reg_timing[ADOP_TIMING_DCS_BIT];
            // phase shift only honoured while the stabilizer runs
            ctl_next.cfg.phase = ctl_reg.reg_timing[ADOP_TIMING_DCS_BIT]
                ? ctl_reg.reg_timing[ADOP_TIMING_PHASE_LSB +: 2] : 2'h0;
            ctl_next.cfg.invert = ctl_reg.reg_timing[ADOP_TIMING_INV_BIT];
            ctl_next.cfg.twos = ctl_reg.reg_format[ADOP_FORMAT_TWOS_BIT];
        end else begin
            // strapped pins control a reduced set of modes
            ctl_next.cfg.drive = ctl_reg.sdi_sync[1] ? ADOP_DRIVE_1M75 : ADOP_DRIVE_3M5;
            ctl_next.cfg.term = 1'b0;
            ctl_next.cfg.sleep = ctl_reg.sck_sync[1];
            ctl_next.cfg.dcs = ctl_reg.cs_sync[1];
            ctl_next.cfg.phase = 2'h0;
            ctl_next.cfg.invert = 1'b0;
            ctl_next.cfg.twos = 1'b0;
        end
        // synchronous reset
        if (!rstn_i) begin
            ctl_next = '0;
            ctl_next.reg_power = ADOP_RST_POWER;
            ctl_next.reg_timing = ADOP_RST_TIMING;
            ctl_next.reg_output = ADOP_RST_OUTPUT;
            ctl_next.reg_format = ADOP_RST_FORMAT;
            ctl_next.cfg.drive = ADOP_DRIVE_3M5;
            ctl_next.cfg.dcs = 1'b1;
        end
    end

    // configuration state register
    always_ff @(posedge clk_i) begin
        ctl_reg <= ctl_next;
    end

    // sample pipeline on the encode rising edge
    always_comb begin
        logic [ADOP_SAMPLE_W:0] word;
        logic enc_rst;
        word = '0;
        enc_rst = ~enc_reg.rst_sync[1];
        enc_next = enc_reg;
        // reset and static config cross in through two flops each, invert through a third
        enc_next.rst_sync = {enc_reg.rst_sync[0], rstn_i};
        enc_next.twos_sync = {enc_reg.twos_sync[0], ctl_reg.cfg.twos};
        enc_next.inv_sync = {enc_reg.inv_sync[0], ctl_reg.cfg.invert};
        enc_next.invert = enc_reg.inv_sync[1];
        // stage 0 captures flag with code; flag rides the same stages
        enc_next.pipe[0] = {core_out_of_range_i, core_code_i};
        // capture stage plus five more, then the lane flop gives seven cycles
        for (int i = 1; i < ADOP_LATENCY; i++) begin
            enc_next.pipe[i] = enc_reg.pipe[i-1];
        end
        word = enc_reg.pipe[ADOP_LATENCY-1];
        if (enc_reg.twos_sync[1]) begin
            word[ADOP_SAMPLE_W-1] = ~word[ADOP_SAMPLE_W-1];
        end
        // split the word into even and odd halves per lane
        for (int l = 0; l < ADOP_LANES; l++) begin
            enc_next.even[l] = word[2*l];
            enc_next.odd_hold[l] = word[2*l+1];
        end
        enc_next.range = word[ADOP_SAMPLE_W];
        enc_next.pos_tog = ~enc_reg.pos_tog;
        if (enc_rst) begin
            enc_next = '0;
            enc_next.rst_sync = enc_reg.rst_sync;
            enc_next.rst_sync[1] = enc_reg.rst_sync[0];
            enc_next.rst_sync[0] = rstn_i;
        end
    end

    // encode domain rising-edge register
    always_ff @(posedge encode_pos_in_i) begin
        enc_reg <= enc_next;
    end

    // falling edge launches the odd half of each lane
    always_ff @(negedge encode_pos_in_i) begin
        if (!enc_reg.rst_sync[1]) begin
            neg_tog_reg <= 1'b0;
            odd_reg <= '0;
        end else begin
            neg_tog_reg <= enc_reg.pos_tog;
            odd_reg <= enc_reg.odd_hold;
        end
    end

    // first half of each output cycle, a pure flop compare
    logic low_half;
    assign low_half = enc_reg.pos_tog ^ neg_tog_reg;

    // ddr lanes, strobe and flag follow the half marker
    always_comb begin
        ddr_bit_pair_lane_o = low_half ? enc_reg.even : odd_reg;
        sample_strobe_out_o = ~low_half ^ enc_reg.invert;
        range_exceeded_flag_o = low_half & enc_reg.range;
    end

    // configuration outputs straight from flops, serial data output tied low
    always_comb begin
        serial_data_o = 1'b0;
        serial_data_oe_o = ctl_reg.sdo_low;
        drive_current_o = ctl_reg.cfg.drive;
        termination_en_o = ctl_reg.cfg.term;
        sleep_o = ctl_reg.cfg.sleep;
        duty_stabilizer_en_o = ctl_reg.cfg.dcs;
        strobe_phase_o = ctl_reg.cfg.phase;
    end

endmodule

`default_nettype wire

// ===== tb/adop_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adop_checker
    import adop_pkg::*;
(
    // clocks and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic encode_pos_in_i,
    // sample path
    input wire logic [ADOP_SAMPLE_W-1:0] core_code_i,
    input wire logic core_out_of_range_i,
    input wire logic [ADOP_LANES-1:0] ddr_bit_pair_lane_o,
    input wire logic sample_strobe_out_o,
    input wire logic range_exceeded_flag_o,
    // configuration pins and driver controls
    input wire logic config_style_select_i,
    input wire logic chip_select_n_i,
    input wire logic serial_data_i,
    input wire logic serial_data_oe_o,
    input wire logic [2:0] drive_current_o,
    input wire logic duty_stabilizer_en_o,
    input wire logic [1:0] strobe_phase_o
);
    logic [6:0][ADOP_SAMPLE_W:0] hist_reg; // core inputs, index = rises ago
    logic [3:0] run_reg; // encode rises since reset, saturating
    logic first_reg; // strobe level in the first half
    logic [ADOP_LANES-1:0] ev_exp; // even bits of the sample due now
    logic [ADOP_LANES-1:0] od_exp; // odd bits of the sample due now
    logic ok; // pipeline refilled after reset
    assign ok = run_reg == 4'hf;
    // history and warm-up count on the encode rise
    always_ff @(posedge encode_pos_in_i) begin
        hist_reg <= {hist_reg[5:0], {core_out_of_range_i, core_code_i}};
        run_reg <= !rstn_i ? 4'h0 : run_reg + {3'h0, !ok};
    end
    // strobe as seen late in the first half
    always_ff @(negedge encode_pos_in_i) begin
        first_reg <= sample_strobe_out_o;
    end
    // split the due sample into lane halves
    always_comb begin
        for (int l = 0; l < ADOP_LANES; l++) begin
            ev_exp[l] = hist_reg[6][2*l];
            od_exp[l] = hist_reg[6][2*l+1];
        end
    end
    property p_even; @(negedge encode_pos_in_i) disable iff (!rstn_i) ok |-> ddr_bit_pair_lane_o == ev_exp; endproperty
    a_even: assert property (p_even) else $error("even lanes wrong");
    property p_odd; @(posedge encode_pos_in_i) disable iff (!rstn_i) ok |-> ddr_bit_pair_lane_o[4:0] == od_exp[4:0];
    endproperty
    a_odd: assert property (p_odd) else $error("odd lanes wrong");
    property p_flag; @(negedge encode_pos_in_i) disable iff (!rstn_i) ok |-> range_exceeded_flag_o == hist_reg[6][12];
    endproperty
    a_flag: assert property (p_flag) else $error("range flag misaligned");
    property p_flag_zero; @(posedge encode_pos_in_i) disable iff (!rstn_i) ok |-> !range_exceeded_flag_o; endproperty
    a_flag_zero: assert property (p_flag_zero) else $error("flag not zero in second half");
    property p_strobe; @(posedge encode_pos_in_i) disable iff (!rstn_i) ok |-> sample_strobe_out_o != first_reg;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe not toggling per half");
    property p_oe_idle; @(posedge clk_i) disable iff (!rstn_i) chip_select_n_i [*6] |-> !serial_data_oe_o; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("readback while deselected");
    property p_phase; @(posedge clk_i) disable iff (!rstn_i) !duty_stabilizer_en_o |-> strobe_phase_o == 2'h0; endproperty
    a_phase: assert property (p_phase) else $error("phase without stabilizer");
    property p_dcs; @(posedge clk_i) disable iff (!rstn_i) (config_style_select_i && chip_select_n_i) [*7]
        |-> duty_stabilizer_en_o; endproperty
    a_dcs: assert property (p_dcs) else $error("stabilizer strap ignored");
    property p_drv; @(posedge clk_i) disable iff (!rstn_i) (config_style_select_i && serial_data_i) [*7]
        |-> drive_current_o == ADOP_DRIVE_1M75; endproperty
    a_drv: assert property (p_drv) else $error("drive strap ignored");
    c_flag: cover property (@(negedge encode_pos_in_i) ok && range_exceeded_flag_o);
    c_read: cover property (@(posedge clk_i) serial_data_oe_o);
    c_strap: cover property (@(posedge clk_i) config_style_select_i && duty_stabilizer_en_o);
endmodule
bind adop_top adop_checker u_chk (.clk_i, .rstn_i, .encode_pos_in_i, .core_code_i, .core_out_of_range_i,
    .ddr_bit_pair_lane_o, .sample_strobe_out_o, .range_exceeded_flag_o, .config_style_select_i,
    .chip_select_n_i, .serial_data_i, .serial_data_oe_o, .drive_current_o, .duty_stabilizer_en_o, .strobe_phase_o);
`default_nettype wire

// ===== tb/adop_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side receiver: samples each half 20 ns after a strobe edge
module adop_rx_model
    import adop_pkg::*;
(
    // ddr link from the converter
    input wire logic [ADOP_LANES-1:0] lanes_i,
    input wire logic strobe_i,
    input wire logic flag_i,
    // reassembled sample
    output logic [ADOP_SAMPLE_W-1:0] word_o,
    output logic flag_o
);
    logic [ADOP_LANES-1:0] even_q; // low-half bits
    logic flag_q; // flag held from the low half
    // capture 20 ns into the half so edge-aligned data has settled
    always @(strobe_i) begin
        #20;
        if (!strobe_i) begin
            even_q = lanes_i;
            flag_q = flag_i;
        end else begin
            for (int l = 0; l < ADOP_LANES; l++) begin
                word_o[2*l] = even_q[l];
                word_o[2*l+1] = lanes_i[l];
            end
            flag_o = flag_q;
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adop_pkg::*;
    logic clk_i = 0, rstn_i = 0, enc = 0, oor = 0, sel = 0, cs_n = 1, sck = 0, sdi = 0;
    logic sdo, oe, strobe, flag, term, sleep, dcs, rx_flag;
    logic [11:0] code = 12'h000;
    logic [11:0] rx_word;
    logic [5:0] lanes;
    logic [2:0] drive;
    logic [1:0] phase;
    integer errors = 0, tests_run = 0;
    // rows: {range input, code input, word expected in offset binary}
    logic [24:0] rows [6] = '{25'h0000000, 25'h1ffffff, 25'h0800800, 25'h07ff7ff, 25'h0a5aa5a, 25'h1001001};
    // config clock, and encode clock offset in phase
    always #25 clk_i = ~clk_i;
    always begin
        if ($time == 0) #7;
        #62.5 enc = ~enc;
    end
    adop_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .encode_pos_in_i(enc), .core_code_i(code),
        .core_out_of_range_i(oor), .config_style_select_i(sel), .chip_select_n_i(cs_n), .serial_clk_i(sck),
        .serial_data_i(sdi), .serial_data_o(sdo), .serial_data_oe_o(oe), .ddr_bit_pair_lane_o(lanes),
        .sample_strobe_out_o(strobe), .range_exceeded_flag_o(flag), .drive_current_o(drive),
        .termination_en_o(term), .sleep_o(sleep), .duty_stabilizer_en_o(dcs), .strobe_phase_o(phase));
    adop_rx_model rx (.lanes_i(lanes), .strobe_i(strobe), .flag_i(flag), .word_o(rx_word), .flag_o(rx_flag));
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // wait n config edges, then step off the edge
    task automatic clks(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask
    // serial frame of n bits msb first; readback taken before each fall
    task automatic spi(input logic [15:0] f, input int n, output logic [7:0] rd);
        rd = 8'h00;
        cs_n = 0;
        for (int b = 15; b >= 16 - n; b--) begin
            sdi = f[b];
            clks(4);
            sck = 1;
            clks(4);
            if (b < 8) rd[b] = !oe;
            sck = 0;
        end
        clks(4);
        cs_n = 1;
        clks(8);
    endtask
    // drive the rows on encode rises and check the rebuilt words
    task automatic stream(input logic twos);
        for (int i = 0; i < 14; i++) begin
            @(posedge enc);
            #5;
            {oor, code} = (i < 6) ? rows[i][24:12] : 13'h0000;
            if (i >= 8) begin
                chk(rx_word, rows[i-8][11:0] ^ {twos, 11'h000});
                chk(rx_flag, rows[i-8][24]);
            end
        end
    endtask
    task automatic complete_run;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        logic [7:0] v;
        clks(20);
        chk({drive, term, sleep, dcs, phase, oe}, 9'h008);
        rstn_i = 1;
        clks(6);
        stream(1'h0);
        spi(16'h0205, 16, v);
        chk({dcs, phase}, 3'h6);
        spi(16'h0204, 16, v);
        chk({dcs, phase}, 3'h0);
        spi(16'h8200, 16, v);
        chk(v, 8'h04);
        chk(sdo, 1'h0);
        // inverted strobe is high in the first half
        spi(16'h0209, 16, v);
        clks(10);
        @(posedge enc);
        #5;
        chk(strobe, 1'h1);
        spi(16'h0201, 16, v);
        // every drive code, termination on odd codes
        for (int c = 0; c < 8; c++) begin
            spi({8'h03, 4'h0, c[0], c[2:0]}, 16, v);
            chk({drive, term}, {(c == 7) ? 3'h0 : c[2:0], c[0]});
        end
        spi(16'h8300, 16, v);
        chk(v, 8'h0f);
        spi(16'h10ff, 16, v);
        spi(16'h9000, 16, v);
        chk(v, 8'h00);
        spi(16'h0101, 12, v);
        chk(sleep, 1'h0);
        spi(16'h0101, 16, v);
        chk(sleep, 1'h1);
        spi(16'h0100, 16, v);
        spi(16'h0401, 16, v);
        stream(1'h1);
        // second reset returns the registers to their reset values
        rstn_i = 0;
        clks(20);
        rstn_i = 1;
        clks(6);
        spi(16'h8300, 16, v);
        chk({v, drive}, 11'h000);
        // strapped pins
        sel = 1;
        sck = 1;
        sdi = 1;
        clks(10);
        chk({drive, sleep, dcs}, {ADOP_DRIVE_1M75, 2'h3});
        cs_n = 0;
        sck = 0;
        sdi = 0;
        clks(10);
        chk({drive, sleep, dcs}, 5'h00);
        complete_run;
    end
    // hang guard
    initial begin
        #1000000;
        errors++;
        complete_run;
    end
endmodule
`default_nettype wire
